// ==== core/pse_port_mode_seq.sv ====
/*
  Eight-port operating mode sequencer with its byte register file.
  Assumes a byte register port decoded from the serial bus and synchronous analog strobes.
*/
`timescale 1ns/1ps
`include "pse_map.svh"
module pse_port_mode_seq #(
  parameter int unsigned TICK_CYC = `PSE_TICK_CYC,
  parameter int unsigned FINGER1_MS = `PSE_FINGER1_MS,
  parameter int unsigned MPS_DROP_MS = `PSE_MPS_DROP_MS,
  parameter int unsigned INT_LOG2 = `PSE_INT_LOG2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rst_pin,
  input wire logic main_supply_rail_ok,
  input wire logic vdd_ok,
  input wire logic auto_res_vld,
  input wire logic [1:0] auto_res_code,
  input wire logic sram_ok,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] det_pt_stb,
  input wire logic [7:0] det_pt_ok,
  input wire logic [31:0] cls_meas,
  input wire logic [7:0] fault,
  input wire logic [7:0] mps_ok,
  input wire logic [7:0] cur_stb,
  input wire logic [111:0] cur_raw,
  output logic [7:0] det_act,
  output logic [7:0] cls_act,
  output logic [7:0] vreset,
  output logic [7:0] pwr_on,
  output logic auto_meas_req
);
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYC - 1);

  if (TICK_CYC < 2 || TICK_CYC > 1048576 || INT_LOG2 < 1 || INT_LOG2 > 8) begin : g_chk
    $error("pse_port_mode_seq: parameter out of range");
  end

  logic [1:0] rst_s_q;
  logic rst_n;
  logic [19:0] div_q;
  logic tick_q;
  logic [7:0] alloc_q, pcut_q, pwr_en_q, det_cmd_q, cls_cmd_q, prst_q, flt_q;
  logic [7:0] prst_d, pwr_v, det_ok_v, ins_v;
  logic [15:0] mode_all;
  logic [31:0] req_all, asg_all;
  logic [111:0] cur_all;
  logic [7:0] rd_val;
  logic rst_wr, dev_rst, rom;
  logic preset, auton;
  logic [1:0] pre_alloc;

  // one byte of a class register: ports 2k (low nibble) and 2k+1
  function automatic logic [7:0] cls_pick(input logic [31:0] all, input logic [1:0] k);
    return all[8 * k +: 8];
  endfunction : cls_pick

  // released through two flops, asserted at once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rst_s_q <= 2'h0;
    else rst_s_q <= {rst_s_q[0], 1'b1};
  end
  assign rst_n = rst_s_q[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 20'h0_0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q == TICK_LAST;
      div_q <= (div_q == TICK_LAST) ? 20'h0_0000 : div_q + 20'h0_0001;
    end
  end

  pse_cfg_load u_cfg (
    .clk(clk),
    .rst_n(rst_n),
    .rst_pin(rst_pin),
    .reset_all(rst_wr && reg_wdata[`PSE_RST_ALL_BIT]),
    .main_supply_rail_ok(main_supply_rail_ok),
    .vdd_ok(vdd_ok),
    .res_vld(auto_res_vld),
    .res_code(auto_res_code),
    .meas_req(auto_meas_req),
    .preset(preset),
    .auton(auton),
    .alloc(pre_alloc)
  );

  assign rst_wr = reg_wr && reg_addr == `PSE_OFS_RST_CMD;
  assign dev_rst = rst_pin || (rst_wr && reg_wdata[`PSE_RST_ALL_BIT]);
  assign rom = auton && !sram_ok;

  // bits 3:0 reset ports n and n+4 together
  always_comb begin
    prst_d = 8'h00;
    if (dev_rst) prst_d = 8'hff;
    else if (rst_wr) prst_d = {reg_wdata[3:0], reg_wdata[3:0]};
  end

  // one-cycle command pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prst_q <= 8'h00;
      pwr_en_q <= 8'h00;
      det_cmd_q <= 8'h00;
      cls_cmd_q <= 8'h00;
    end else begin
      prst_q <= prst_d;
      pwr_en_q <= (reg_wr && reg_addr == `PSE_OFS_PWR_EN) ? reg_wdata : 8'h00;
      det_cmd_q <= (reg_wr && reg_addr == `PSE_OFS_DET_CMD) ? reg_wdata : 8'h00;
      cls_cmd_q <= (reg_wr && reg_addr == `PSE_OFS_CLS_CMD) ? reg_wdata : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alloc_q <= `PSE_ALLOC_RST;
      pcut_q <= `PSE_PCUT_RST;
    end else if (preset) begin
      alloc_q <= {4{pre_alloc}};
    end else if (reg_wr) begin
      if (reg_addr == `PSE_OFS_ALLOC) alloc_q <= reg_wdata;
      if (reg_addr == `PSE_OFS_PCUT) pcut_q <= reg_wdata;
    end
  end

  // start fault with insufficient power; an event wins over the clear on read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) flt_q <= 8'h00;
    else if (reg_rd && reg_addr == `PSE_OFS_START_FLT) flt_q <= ins_v;
    else flt_q <= flt_q | ins_v;
  end

  genvar i;
  for (i = 0; i < 8; i++) begin : g_port
    localparam logic [7:0] MODE_OFS = `PSE_OFS_MODE_LO + 8'(i / 4);
    pse_pkg::pse_mode_t mode_q;
    logic resume_q;
    logic mw;
    logic [1:0] mwd;
    logic [INT_LOG2-1:0] n_q;
    logic [13+INT_LOG2:0] acc_q, sum;
    logic [13:0] avg_q;

    pse_port_if pif ();

    assign mw = reg_wr && reg_addr == MODE_OFS;
    assign mwd = reg_wdata[2 * (i % 4) +: 2];

    // each port holds its own mode
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mode_q <= pse_pkg::PSE_M_OFF;
      end else if (preset) begin
        mode_q <= pse_pkg::PSE_M_AUTO;
      end else if (resume_q) begin
        mode_q <= pse_pkg::PSE_M_AUTO;
      end else if (prst_d[i] && auton && sram_ok) begin
        mode_q <= pse_pkg::PSE_M_OFF;
      end else if (mw) begin
        mode_q <= pse_pkg::pse_mode_t'(mwd);
      end
    end

    // from rom, an off event drops the port one cycle then resumes
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) resume_q <= 1'b0;
      else resume_q <= rom && (prst_d[i] || (mw && mwd == 2'h0));
    end

    assign sum = acc_q + {{INT_LOG2{1'b0}}, cur_raw[14 * i +: 14]};

    // averaging over 2**INT_LOG2 samples keeps 14 bits of telemetry
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        n_q <= '0;
        acc_q <= '0;
        avg_q <= 14'h0000;
      end else if (cur_stb[i]) begin
        n_q <= n_q + 1'b1;
        if (&n_q) begin
          avg_q <= sum[13+INT_LOG2:INT_LOG2];
          acc_q <= '0;
        end else begin
          acc_q <= sum;
        end
      end
    end

    assign pif.mode = mode_q;
    assign pif.alloc = alloc_q[2 * (i % 4) +: 2];
    assign pif.pwr_en = pwr_en_q[i];
    assign pif.det_cmd = det_cmd_q[i];
    assign pif.cls_cmd = cls_cmd_q[i];
    assign pif.port_rst = prst_q[i];
    assign pif.tick = tick_q;
    assign pif.over_pcut = avg_q[13:6] > pcut_q;
    assign pif.det_pt_stb = det_pt_stb[i];
    assign pif.det_pt_ok = det_pt_ok[i];
    assign pif.fault = fault[i];
    assign pif.mps_ok = mps_ok[i];
    assign pif.cls_meas = cls_meas[4 * i +: 4];

    pse_port_seq #(
      .FINGER1_MS(FINGER1_MS),
      .MPS_DROP_MS(MPS_DROP_MS)
    ) u_seq (
      .clk(clk),
      .rst_n(rst_n),
      .p(pif.seq)
    );

    assign det_act[i] = pif.det_act;
    assign cls_act[i] = pif.cls_act;
    assign vreset[i] = pif.vreset;
    assign pwr_on[i] = pif.pwr_on;
    assign pwr_v[i] = pif.pwr_on;
    assign det_ok_v[i] = pif.det_ok;
    assign ins_v[i] = pif.insuff;
    assign mode_all[2 * i +: 2] = mode_q;
    assign req_all[4 * i +: 4] = pif.req_cls;
    assign asg_all[4 * i +: 4] = pif.asg_cls;
    assign cur_all[14 * i +: 14] = avg_q;
  end

  // reads stay served in every mode, autonomous included
  always_comb begin
    rd_val = 8'h00;
    unique case (reg_addr) inside
      [`PSE_OFS_REQ_CLS : `PSE_OFS_REQ_CLS + 8'h03]: rd_val = cls_pick(req_all, reg_addr[1:0]);
      [`PSE_OFS_ASG_CLS : `PSE_OFS_ASG_CLS + 8'h03]: rd_val = cls_pick(asg_all, reg_addr[1:0]);
      [`PSE_OFS_CUR : `PSE_OFS_CUR + 8'h0f]: begin
        if (reg_addr[0]) rd_val = {2'h0, cur_all[14 * reg_addr[3:1] + 8 +: 6]};
        else rd_val = cur_all[14 * reg_addr[3:1] +: 8];
      end
      `PSE_OFS_STAT: rd_val = pwr_v;
      `PSE_OFS_DET_STAT: rd_val = det_ok_v;
      `PSE_OFS_MODE_LO: rd_val = mode_all[7:0];
      `PSE_OFS_MODE_HI: rd_val = mode_all[15:8];
      `PSE_OFS_PCUT: rd_val = pcut_q;
      `PSE_OFS_START_FLT: rd_val = flt_q;
      `PSE_OFS_ALLOC: rd_val = alloc_q;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_val;
  end

  a_preset_auto: assert property (@(posedge clk) disable iff (!rst_n)
    preset |=> mode_all == 16'hffff && alloc_q == {4{$past(pre_alloc)}})
    else $error("preset did not load autonomous setup");
  a_rom_resume: assert property (@(posedge clk) disable iff (!rst_n)
    (rom && prst_d[0] && !preset) |=> ##1 mode_all[1:0] == 2'h3)
    else $error("rom autonomous port did not resume");
endmodule : pse_port_mode_seq

// ==== core/pse_map.svh ====
/*
  Offsets, field positions, reset values and timing counts of the port mode sequencer.
  Assumes a 50 MHz core clock and byte-wide registers at their printed offsets.
*/
`ifndef PSE_MAP_SVH
`define PSE_MAP_SVH
`define PSE_OFS_REQ_CLS 8'h0c
`define PSE_OFS_STAT 8'h10
`define PSE_OFS_DET_STAT 8'h11
`define PSE_OFS_MODE_LO 8'h12
`define PSE_OFS_MODE_HI 8'h13
`define PSE_OFS_PWR_EN 8'h19
`define PSE_OFS_RST_CMD 8'h1a
`define PSE_OFS_DET_CMD 8'h1c
`define PSE_OFS_CLS_CMD 8'h1d
`define PSE_OFS_PCUT 8'h1e
`define PSE_OFS_START_FLT 8'h24
`define PSE_OFS_ALLOC 8'h29
`define PSE_OFS_CUR 8'h30
`define PSE_OFS_ASG_CLS 8'h4c
`define PSE_RST_ALL_BIT 4
`define PSE_ALLOC_RST 8'hff
`define PSE_PCUT_RST 8'hff
`define PSE_CLK_HZ 50000000
`define PSE_TICK_US 1000
`define PSE_TICK_CYC (`PSE_CLK_HZ / 1000000 * `PSE_TICK_US)
`define PSE_FINGER1_MS 100
`define PSE_MPS_DROP_MS 6
`define PSE_DET_POINTS 4
`define PSE_INT_LOG2 4
`endif

// ==== core/pse_pkg.sv ====
/*
  Types and the power demotion decode of the port mode sequencer.
  Assumes classes are 4-bit codes and allocation is a 2-bit code, 0 = class 1 .. 3 = class 4.
*/
package pse_pkg;
  typedef enum logic [1:0] {
    PSE_M_OFF = 2'h0,
    PSE_M_MAN = 2'h1,
    PSE_M_SEMI = 2'h2,
    PSE_M_AUTO = 2'h3
  } pse_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DET = 3'h1,
    ST_CLS = 3'h3,
    ST_FING = 3'h2,
    ST_PWR = 3'h6
  } pse_state_t;

  // returns {insufficient power, assigned class}
  function automatic logic [4:0] pse_demote(input logic [3:0] req, input logic [1:0] alloc);
    logic [3:0] lim;
    lim = {2'h0, alloc} + 4'h1;
    if (req <= lim) return {1'b0, req};
    if (alloc < 2'h2) return {1'b1, 4'h0};
    return {1'b0, lim};
  endfunction : pse_demote
endpackage : pse_pkg

// ==== core/pse_port_if.sv ====
/*
  Per-port carrier between the register core and one port sequencer.
  Assumes one instance per port; all signals are synchronous to the core clock.
*/
`timescale 1ns/1ps
interface pse_port_if;
  pse_pkg::pse_mode_t mode;
  logic [1:0] alloc;
  logic pwr_en, det_cmd, cls_cmd, port_rst, tick, over_pcut;
  logic det_pt_stb, det_pt_ok, fault, mps_ok;
  logic [3:0] cls_meas;
  logic det_act, cls_act, vreset, pwr_on, det_ok, cls_ok, insuff;
  logic [3:0] req_cls, asg_cls;
  modport ctl(output mode, alloc, pwr_en, det_cmd, cls_cmd, port_rst, tick, over_pcut,
    det_pt_stb, det_pt_ok, fault, mps_ok, cls_meas,
    input det_act, cls_act, vreset, pwr_on, det_ok, cls_ok, insuff, req_cls, asg_cls);
  modport seq(input mode, alloc, pwr_en, det_cmd, cls_cmd, port_rst, tick, over_pcut,
    det_pt_stb, det_pt_ok, fault, mps_ok, cls_meas,
    output det_act, cls_act, vreset, pwr_on, det_ok, cls_ok, insuff, req_cls, asg_cls);
endinterface : pse_port_if

// ==== core/pse_port_seq.sv ====
/*
  One port's detection, classification, power-on and shutdown sequencer.
  Assumes a 1 ms tick pulse and synchronous analog result strobes.
*/
`timescale 1ns/1ps
`include "pse_map.svh"
module pse_port_seq #(
  parameter int unsigned FINGER1_MS = `PSE_FINGER1_MS,
  parameter int unsigned MPS_DROP_MS = `PSE_MPS_DROP_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  pse_port_if.seq p
);
  localparam logic [6:0] F1_LAST = 7'(FINGER1_MS - 1);
  localparam logic [2:0] MPS_LAST = 3'(MPS_DROP_MS - 1);
  localparam logic [1:0] PT_LAST = 2'(`PSE_DET_POINTS - 1);

  pse_pkg::pse_state_t st_q, st_d;
  logic [6:0] ms_q;
  logic [2:0] mps_q;
  logic [1:0] pts_q, fing_q;
  logic all_ok_q, en_pend_q;
  logic [4:0] dem;
  logic man, run, fing1_end, pts_last, mps_lost;

  if (FINGER1_MS < 1 || FINGER1_MS > 128 || MPS_DROP_MS < 1 || MPS_DROP_MS > 8) begin : g_chk
    $error("pse_port_seq: count out of range");
  end

  assign man = p.mode == pse_pkg::PSE_M_MAN;
  assign run = p.mode inside {pse_pkg::PSE_M_SEMI, pse_pkg::PSE_M_AUTO};
  assign dem = pse_pkg::pse_demote(p.cls_meas, p.alloc);
  assign fing1_end = st_q == pse_pkg::ST_CLS && p.tick && ms_q == F1_LAST;
  assign pts_last = st_q == pse_pkg::ST_DET && p.det_pt_stb && pts_q == PT_LAST;
  assign mps_lost = !p.mps_ok && p.tick && mps_q == MPS_LAST;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      pse_pkg::ST_IDLE: begin
        if (man && p.pwr_en) st_d = pse_pkg::ST_PWR;
        else if (p.mode == pse_pkg::PSE_M_SEMI && en_pend_q) st_d = pse_pkg::ST_PWR;
        else if (run || (man && p.det_cmd)) st_d = pse_pkg::ST_DET;
        else if (man && p.cls_cmd) st_d = pse_pkg::ST_CLS;
      end
      pse_pkg::ST_DET: begin
        if (pts_last) begin
          st_d = (!man && all_ok_q && p.det_pt_ok) ? pse_pkg::ST_CLS : pse_pkg::ST_IDLE;
        end
      end
      pse_pkg::ST_CLS: begin
        if (fing1_end) st_d = (!man && dem[4]) ? pse_pkg::ST_IDLE : pse_pkg::ST_FING;
      end
      pse_pkg::ST_FING: begin
        if (fing_q == 2'h0 && p.tick) begin
          st_d = (p.mode == pse_pkg::PSE_M_AUTO) ? pse_pkg::ST_PWR : pse_pkg::ST_IDLE;
        end
      end
      pse_pkg::ST_PWR: begin
        if (p.fault || p.over_pcut || mps_lost) st_d = pse_pkg::ST_IDLE;
      end
      default: st_d = pse_pkg::ST_IDLE;
    endcase
    if (p.port_rst || p.mode == pse_pkg::PSE_M_OFF) st_d = pse_pkg::ST_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st_q <= pse_pkg::ST_IDLE;
    else st_q <= st_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p.det_act <= 1'b0;
      p.cls_act <= 1'b0;
      p.pwr_on <= 1'b0;
      p.vreset <= 1'b0;
    end else begin
      p.det_act <= st_d == pse_pkg::ST_DET;
      p.cls_act <= st_d inside {pse_pkg::ST_CLS, pse_pkg::ST_FING};
      p.pwr_on <= st_d == pse_pkg::ST_PWR;
      // manual class ends with a port voltage reset
      p.vreset <= man && st_q == pse_pkg::ST_FING && st_d == pse_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_q <= 7'h00;
      pts_q <= 2'h0;
      all_ok_q <= 1'b1;
      mps_q <= 3'h0;
      fing_q <= 2'h0;
    end else begin
      if (st_q != pse_pkg::ST_CLS) ms_q <= 7'h00;
      else if (p.tick) ms_q <= ms_q + 7'h01;
      if (st_q != pse_pkg::ST_DET) begin
        pts_q <= 2'h0;
        all_ok_q <= 1'b1;
      end else if (p.det_pt_stb) begin
        pts_q <= pts_q + 2'h1;
        all_ok_q <= all_ok_q && p.det_pt_ok;
      end
      if (st_q != pse_pkg::ST_PWR || p.mps_ok) mps_q <= 3'h0;
      else if (p.tick) mps_q <= mps_q + 3'h1;
      // demotion to 15.4 W shows one finger, 30 W shows three
      if (fing1_end) fing_q <= (dem[3:0] >= 4'h4) ? 2'h2 : 2'h0;
      else if (st_q == pse_pkg::ST_FING && p.tick && fing_q != 2'h0) fing_q <= fing_q - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p.det_ok <= 1'b0;
      p.cls_ok <= 1'b0;
      p.req_cls <= 4'h0;
      p.asg_cls <= 4'h0;
      p.insuff <= 1'b0;
      en_pend_q <= 1'b0;
    end else if (p.mode == pse_pkg::PSE_M_OFF || p.port_rst) begin
      p.det_ok <= 1'b0;
      p.cls_ok <= 1'b0;
      p.req_cls <= 4'h0;
      p.asg_cls <= 4'h0;
      p.insuff <= 1'b0;
      en_pend_q <= 1'b0;
    end else begin
      p.insuff <= fing1_end && !man && dem[4];
      if (pts_last) p.det_ok <= all_ok_q && p.det_pt_ok;
      if (fing1_end) begin
        p.req_cls <= p.cls_meas;
        p.cls_ok <= !dem[4];
        p.asg_cls <= man ? 4'h0 : dem[3:0];
      end
      if (man && st_q == pse_pkg::ST_IDLE && st_d == pse_pkg::ST_PWR) p.asg_cls <= 4'h0;
      if (p.mode == pse_pkg::PSE_M_SEMI && p.pwr_en && p.cls_ok) en_pend_q <= 1'b1;
      else if (st_d == pse_pkg::ST_PWR || p.mode != pse_pkg::PSE_M_SEMI) en_pend_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_off_no_power: assert property (p.mode == pse_pkg::PSE_M_OFF |=> !p.pwr_on)
    else $error("port powered in off mode");
  a_semi_enable: assert property (
    (st_q == pse_pkg::ST_IDLE && st_d == pse_pkg::ST_PWR && p.mode == pse_pkg::PSE_M_SEMI)
    |-> en_pend_q) else $error("semiauto port powered without enable");
  a_manual_now: assert property (
    (man && st_q == pse_pkg::ST_IDLE && p.pwr_en && !p.port_rst) |=> p.pwr_on)
    else $error("manual enable did not power port");
  a_four_points: assert property (
    (st_q == pse_pkg::ST_DET && st_d == pse_pkg::ST_CLS) |-> pts_q == PT_LAST && all_ok_q)
    else $error("class started without four good points");
  a_finger_len: assert property (
    (st_q == pse_pkg::ST_CLS && st_d == pse_pkg::ST_FING) |-> ms_q == F1_LAST && p.tick)
    else $error("first finger length wrong");
  a_insuff_off: assert property (p.insuff |-> !p.pwr_on ##1 !p.pwr_on)
    else $error("port powered despite insufficient power");
  a_manual_asg: assert property (
    ($rose(p.pwr_on) && $past(man)) |-> p.asg_cls == 4'h0)
    else $error("manual power set an assigned class");
  a_mps_drop: assert property (
    (st_q == pse_pkg::ST_PWR && mps_lost) |=> !p.pwr_on)
    else $error("port kept power after signature loss");
  a_fault_off: assert property ((p.pwr_on && p.fault) |=> !p.pwr_on)
    else $error("port kept power during fault");
endmodule : pse_port_seq

// ==== core/pse_cfg_load.sv ====
/*
  Configuration resistor measurement and register preset for autonomous start.
  Assumes the resistor converter answers a held request with a one-cycle result strobe.
*/
`timescale 1ns/1ps
module pse_cfg_load (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rst_pin,
  input wire logic reset_all,
  input wire logic main_supply_rail_ok,
  input wire logic vdd_ok,
  input wire logic res_vld,
  input wire logic [1:0] res_code,
  output logic meas_req,
  output logic preset,
  output logic auton,
  output logic [1:0] alloc
);
  logic pu_q;
  logic sup_ok;

  assign sup_ok = main_supply_rail_ok && vdd_ok;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_q <= 1'b1;
      meas_req <= 1'b0;
      preset <= 1'b0;
      auton <= 1'b0;
      alloc <= 2'h3;
    end else begin
      preset <= 1'b0;
      if (rst_pin || reset_all) meas_req <= 1'b1;
      else if (meas_req && res_vld) meas_req <= 1'b0;
      else if (pu_q && sup_ok) meas_req <= 1'b1;
      // preset only once, on the first result after both supplies are up
      if (meas_req && res_vld && pu_q && sup_ok) begin
        pu_q <= 1'b0;
        if (res_code != 2'h0) begin
          preset <= 1'b1;
          auton <= 1'b1;
          alloc <= (res_code == 2'h1) ? 2'h2 : 2'h3;
        end
      end
    end
  end
endmodule : pse_cfg_load

// ==== sim/pse_pd_model.sv ====
/*
  Powered device model on the port links; assumes the sequencer clock, presence set by bench.
*/
`timescale 1ns/1ps
module pse_pd_model (
  input wire logic clk,
  input wire logic [7:0] det_act,
  input wire logic [7:0] pwr_on,
  input wire logic [7:0] present,
  output logic [7:0] det_pt_stb,
  output logic [7:0] det_pt_ok,
  output logic [7:0] mps_ok
);
  logic [1:0] div_q = 2'h0;
  // ok inverted off the strobe so a stale level always reads the opposite result
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    det_pt_stb <= det_act & {8{div_q == 2'h3}};
    det_pt_ok <= (div_q == 2'h3) ? present : ~present;
    mps_ok <= present & pwr_on;
  end
endmodule : pse_pd_model

// ==== sim/pse_port_mode_seq_test.sv ====
/*
  Bench of the port mode sequencer; needs pse_pd_model and shortened tick counts.
*/
`timescale 1ns/1ps
module pse_port_mode_seq_test;
  localparam int T = 50, F = 4, M = 2;
  logic clk = 1'h0, resetn = 1'h0, rst_pin = 1'h0, auto_res_vld = 1'h0, reg_wr = 1'h0;
  logic reg_rd = 1'h0, auto_meas_req;
  logic [1:0] auto_res_code = 2'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, fault = 8'h00, present = 8'hff;
  logic main_supply_rail_ok = 1'h1, sram_ok = 1'h0;
  logic [7:0] cur_stb = 8'h00;
  logic [111:0] cur_raw = 112'h0;
  logic [13:0] ir;
  logic [7:0] reg_rdata, det_pt_stb, det_pt_ok, mps_ok, det_act, cls_act, vreset, pwr_on;
  logic [31:0] cls_meas;
  logic [3:0] c0;
  int n_fail = 0, num_checks = 0, n = 0, v = 0, xf = 0;
  pse_port_mode_seq #(.TICK_CYC(T), .FINGER1_MS(F), .MPS_DROP_MS(M)) u_dut (.clk, .resetn,
    .rst_pin, .main_supply_rail_ok, .vdd_ok(1'h1), .auto_res_vld, .auto_res_code, .sram_ok,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .det_pt_stb, .det_pt_ok, .cls_meas,
    .fault, .mps_ok, .cur_stb, .cur_raw, .det_act, .cls_act, .vreset, .pwr_on,
    .auto_meas_req);
  pse_pd_model u_pd (.clk, .det_act, .pwr_on, .present, .det_pt_stb, .det_pt_ok, .mps_ok);
  task automatic chk(input string what, input logic [7:0] x, input logic [7:0] g);
    num_checks++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, x, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, d, m);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk);
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    @(negedge clk);
    if (!w) chk($sformatf("reg %h", a), d, reg_rdata & m);
  endtask : acc
  task automatic measure(input logic [1:0] code);
    for (int k = 0; k < 50 && auto_meas_req !== 1'h1; k++) @(negedge clk);
    chk("meas", 8'h01, {7'h00, auto_meas_req});
    auto_res_code = code;
    auto_res_vld = 1'h1;
    @(negedge clk);
    auto_res_vld = 1'h0;
  endtask : measure
  function automatic logic [7:0] exp_asg(input logic [3:0] r, input logic [1:0] a);
    return (r <= 4'(a) + 4'h1) ? {4'h0, r} : (a < 2'h2) ? 8'h10 : {4'h0, 4'(a) + 4'h1};
  endfunction : exp_asg
  task automatic conclude();
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  initial forever #10 clk = ~clk;
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    void'($urandom(32'h80e2_9916));
    c0 = 4'h1 + 4'($urandom % 4);
    // class 4 on a 30 W port shows three fingers, lower classes one
    xf = (c0 > 4'h3) ? 3 : 1;
    ir = 14'($urandom);
    cls_meas = {20'h0_0000, 4'h3, 4'h2, c0};
    repeat (5) @(negedge clk);
    resetn = 1'h1;
    measure(2'h0);
    acc(1'h0, 8'h29, 8'hff, 8'hff);
    acc(1'h1, 8'h29, 8'hdf, 8'h00);
    acc(1'h1, 8'h12, 8'h3b, 8'h00);
    for (int k = 0; k < 2000 && pwr_on[0] !== 1'h1; k++) @(negedge clk);
    chk("auto", 8'h01, pwr_on & 8'h01);
    chk("held", 8'h00, pwr_on & 8'h06);
    acc(1'h0, 8'h0c, {4'h2, c0}, 8'hff);
    acc(1'h0, 8'h4c, exp_asg(c0, 2'h3) & 8'h0f, 8'h0f);
    acc(1'h0, 8'h24, (exp_asg(4'h3, 2'h1) >> 2) & 8'h04, 8'h04);
    acc(1'h1, 8'h19, 8'h02, 8'h00);
    for (int k = 0; k < 2000 && pwr_on[1] !== 1'h1; k++) @(negedge clk);
    chk("semi", 8'h02, pwr_on & 8'h02);
    fault = 8'h01;
    repeat (3) @(negedge clk);
    chk("flt", 8'h00, pwr_on & 8'h01);
    fault = 8'h00;
    present = 8'hfd;
    repeat ((M + 1) * T + 4) @(negedge clk);
    chk("mps", 8'h00, pwr_on & 8'h02);
    acc(1'h1, 8'h12, 8'h00, 8'h00);
    acc(1'h0, 8'h10, 8'h00, 8'hff);
    acc(1'h1, 8'h12, 8'h01, 8'h00);
    acc(1'h1, 8'h1d, 8'h01, 8'h00);
    repeat ((F + 4) * T) begin
      @(negedge clk);
      n += int'(cls_act[0]);
      v += int'(vreset[0]);
    end
    chk("vreset", 8'h01, 8'(v));
    chk("finger", 8'h01, {7'h00, n > (F + xf - 1) * T - 4 && n <= (F + xf) * T + 4});
    acc(1'h1, 8'h19, 8'h01, 8'h00);
    @(negedge clk);
    chk("man", 8'h01, pwr_on & 8'h01);
    chk("quiet", 8'h00, (det_act | cls_act) & 8'h01);
    acc(1'h0, 8'h4c, 8'h00, 8'h0f);
    rst_pin = 1'h1;
    @(negedge clk);
    rst_pin = 1'h0;
    measure(2'h1);
    acc(1'h0, 8'h12, 8'h00, 8'hfc);
    resetn = 1'h0;
    main_supply_rail_ok = 1'h0;
    repeat (2) @(negedge clk);
    resetn = 1'h1;
    repeat (10) @(negedge clk);
    chk("supply", 8'h00, {7'h00, auto_meas_req});
    main_supply_rail_ok = 1'h1;
    measure(2'h1);
    @(negedge clk);
    acc(1'h0, 8'h13, 8'hff, 8'hff);
    acc(1'h0, 8'h29, 8'haa, 8'hff);
    acc(1'h1, 8'h12, 8'h00, 8'h00);
    acc(1'h0, 8'h12, 8'hff, 8'hff);
    acc(1'h1, 8'h1a, 8'h01, 8'h00);
    acc(1'h0, 8'h12, 8'hff, 8'hff);
    sram_ok = 1'h1;
    acc(1'h1, 8'h1a, 8'h01, 8'h00);
    acc(1'h0, 8'h13, 8'hfc, 8'hff);
    cur_raw[13:0] = ir;
    cur_stb = 8'h01;
    repeat (16) @(negedge clk);
    cur_stb = 8'h00;
    acc(1'h0, 8'h30, ir[7:0], 8'hff);
    acc(1'h0, 8'h31, {2'h0, ir[13:8]}, 8'hff);
    conclude();
  end
endmodule : pse_port_mode_seq_test
